// ### rtl/sync_tx_map.vh
// register offsets, field positions, reset values and timing counts of the sync transmitter
`ifndef SYNC_TX_MAP_VH
`define SYNC_TX_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PERIPHERAL_FLAGS_ONE 12'h000
`define OFS_PERIPHERAL_ENABLES_ONE 12'h004
`define OFS_PERIPHERAL_PRIORITIES_ONE 12'h008
`define OFS_RECEIVE_STATUS_CONTROL 12'h00c
`define OFS_TRANSMIT_BUFFER 12'h010
`define OFS_TRANSMIT_STATUS_CONTROL 12'h014
`define OFS_BAUD_RATE_DIVISOR 12'h018
`define OFS_INTERRUPT_CONTROL 12'h01c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_BUFFER_EMPTY 4
`define BIT_MASTER_CLOCK_SOURCE 7
`define BIT_NINTH_BIT_ENABLE 6
`define BIT_TRANSMIT_ENABLE 5
`define BIT_CLOCKED_MODE 4
`define BIT_SHIFTER_EMPTY 1
`define BIT_NINTH_BIT_VALUE 0
`define BIT_PORT_ENABLE 7
`define BIT_RX_SINGLE 5
`define BIT_RX_CONT 4
// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_TRANSMIT_STATUS_CONTROL 8'h02
`define RST_BAUD_RATE_DIVISOR 8'h00
`define RST_BYTE_ZERO 8'h00
`define WMASK_TRANSMIT_STATUS_CONTROL 8'hf5
`define WMASK_RECEIVE_STATUS_CONTROL 8'hf0
`define WMASK_INTERRUPT_CONTROL 8'hff
// ----------------------------------------------------------------
// timing: one instruction cycle is four system clocks
// ----------------------------------------------------------------
`define INSTR_CYCLE_CLOCKS 2'd3
`endif

// ### rtl/sync_tx_clock_divider.v
// baud divider making one-cycle half-period enable pulses for the shift clock
`default_nettype none
module sync_tx_clock_divider (
  // clock and reset
  input wire i_clock,
  input wire i_rstn,
  // control
  input wire i_run,
  input wire [7:0] i_divisor,
  // tick out
  output reg o_tick
);
  // ------------------------------------------------------------
  // down counter: a tick every divisor+1 instruction cycles
  // ------------------------------------------------------------
  reg [9:0] count_r; // counts system clocks
  wire [9:0] period = {i_divisor, 2'b11}; // (divisor+1)*4 - 1 clocks
  // reload at terminal count, idle while stopped
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= 10'h000;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count_r <= period;
      o_tick <= 1'b0;
    end else if (count_r == 10'h000) begin
      count_r <= period;
      o_tick <= 1'b1;
    end else begin
      count_r <= count_r - 10'h001;
      o_tick <= 1'b0;
    end
  end
endmodule // sync_tx_clock_divider
`default_nettype wire

// ### rtl/sync_tx_master.v
// synchronous master transmitter with ahb-lite register slave
// Summary of operation
// - transmit and receive never run together
// - clocked-mode bit selects synchronous operation
// - port enable turns pins into clock/data
// - master clock source drives shift clock
// - shifter reloads only after last bit
// - buffer move takes one instruction cycle
// - empty flag set by move, cleared by write
// - irq enable gates only the request
// - flag drop valid second cycle after write
// - shifter-empty status bit, read only, polled
// - shift register not visible to software
// - ninth bit value sent in 9-bit mode
// - writing holding buffer starts transmission
// - resets give control 0x02, divisor zero
`default_nettype none
`include "sync_tx_map.vh"
module sync_tx_master (
  // clock and reset
  input wire i_clock,
  input wire i_rstn,
  // ahb-lite slave
  input wire i_hsel,
  input wire [11:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire o_hreadyout,
  output wire o_hresp,
  output reg [31:0] o_hrdata,
  // serial clock line, two-way pin
  input wire i_serial_clock_line,
  output reg o_serial_clock_line,
  output reg o_serial_clock_line_oen,
  // serial data line, two-way pin
  input wire i_serial_data_line,
  output reg o_serial_data_line,
  output reg o_serial_data_line_oen,
  // interrupt and status
  output wire o_irq,
  output wire o_receive_inhibit
);
  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001; // shifter empty
  localparam [2:0] ST_LOAD = 3'b010; // buffer to shifter move
  localparam [2:0] ST_SHIFT = 3'b100; // bits going out
  reg [2:0] state_r;
  reg [7:0] transmit_control_register_r; // tx status and control
  reg [7:0] receive_control_register_r; // rx control, receive path not built here
  reg [7:0] baud_divisor_register_r;
  reg [7:0] transmit_holding_buffer_r;
  reg [7:0] peripheral_enable_register_r;
  reg [7:0] peripheral_priorities_r; // kept for software only
  reg [7:0] interrupt_control_r; // kept for software only
  reg buffer_full_r; // holding buffer holds an unsent word
  reg buffer_empty_flag_r; // visible flag, lags the write
  reg [1:0] flag_delay_r; // delays the visible drop of the flag
  reg [8:0] output_shift_register_r; // not mapped to software
  reg [3:0] bits_left_r; // bits still to send
  reg [1:0] load_count_r; // clocks of the buffer move
  reg clock_phase_r; // 0 first half of a bit, 1 second
  // pin inputs synchronised although unused by transmit path
  reg [1:0] clock_pin_sync_r;
  reg [1:0] data_pin_sync_r;
  // ------------------------------------------------------------
  // ahb-lite address phase capture
  // ------------------------------------------------------------
  reg wr_pend_r; // write data phase pending
  reg [11:0] wr_addr_r;
  wire take = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1; // zero wait states
  assign o_hresp = 1'b0; // always okay
  // decoded control bits
  wire clocked_mode = transmit_control_register_r[`BIT_CLOCKED_MODE];
  wire port_enable = receive_control_register_r[`BIT_PORT_ENABLE];
  wire master_clock = transmit_control_register_r[`BIT_MASTER_CLOCK_SOURCE];
  wire tx_enable = transmit_control_register_r[`BIT_TRANSMIT_ENABLE];
  wire nine_bit = transmit_control_register_r[`BIT_NINTH_BIT_ENABLE];
  wire master_active = clocked_mode && port_enable && master_clock;
  wire run = master_active && tx_enable;
  wire shifter_empty = (state_r == ST_IDLE);
  wire tick;
  // masked write of an 8-bit register
  function [7:0] merge;
    input [7:0] old_value;
    input [7:0] new_value;
    input [7:0] mask;
    begin
      merge = (old_value & ~mask) | (new_value & mask);
    end
  endfunction
  // ------------------------------------------------------------
  // divider for the shift clock
  // ------------------------------------------------------------
  sync_tx_clock_divider u_divider (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_run(run && (state_r == ST_SHIFT)),
    .i_divisor(baud_divisor_register_r),
    .o_tick(tick)
  );
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      clock_pin_sync_r <= 2'b00;
      data_pin_sync_r <= 2'b00;
    end else begin
      clock_pin_sync_r <= {clock_pin_sync_r[0], i_serial_clock_line};
      data_pin_sync_r <= {data_pin_sync_r[0], i_serial_data_line};
    end
  end
  // ------------------------------------------------------------
  // bus write capture
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else if (i_hready) begin
      wr_pend_r <= take && i_hwrite;
      wr_addr_r <= i_haddr;
    end
  end
  wire wr_buffer = wr_pend_r && (wr_addr_r == `OFS_TRANSMIT_BUFFER);
  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      transmit_control_register_r <= `RST_TRANSMIT_STATUS_CONTROL;
      baud_divisor_register_r <= `RST_BAUD_RATE_DIVISOR;
      receive_control_register_r <= `RST_BYTE_ZERO;
      transmit_holding_buffer_r <= `RST_BYTE_ZERO;
      peripheral_enable_register_r <= `RST_BYTE_ZERO;
      peripheral_priorities_r <= `RST_BYTE_ZERO;
      interrupt_control_r <= `RST_BYTE_ZERO;
    end else if (wr_pend_r) begin
      if (wr_addr_r == `OFS_TRANSMIT_STATUS_CONTROL) begin
        transmit_control_register_r <= merge(transmit_control_register_r, i_hwdata[7:0],
                                             `WMASK_TRANSMIT_STATUS_CONTROL);
      end else if (wr_addr_r == `OFS_RECEIVE_STATUS_CONTROL) begin
        receive_control_register_r <= merge(receive_control_register_r, i_hwdata[7:0],
                                            `WMASK_RECEIVE_STATUS_CONTROL);
      end else if (wr_addr_r == `OFS_BAUD_RATE_DIVISOR) begin
        baud_divisor_register_r <= i_hwdata[7:0];
      end else if (wr_addr_r == `OFS_TRANSMIT_BUFFER) begin
        transmit_holding_buffer_r <= i_hwdata[7:0];
      end else if (wr_addr_r == `OFS_PERIPHERAL_ENABLES_ONE) begin
        peripheral_enable_register_r <= i_hwdata[7:0];
      end else if (wr_addr_r == `OFS_PERIPHERAL_PRIORITIES_ONE) begin
        peripheral_priorities_r <= i_hwdata[7:0];
      end else if (wr_addr_r == `OFS_INTERRUPT_CONTROL) begin
        interrupt_control_r <= merge(interrupt_control_r, i_hwdata[7:0],
                                     `WMASK_INTERRUPT_CONTROL);
      end
    end
  end
  // ------------------------------------------------------------
  // transmit state machine
  // ------------------------------------------------------------
  wire move_done = (state_r == ST_LOAD) && (load_count_r == `INSTR_CYCLE_CLOCKS);
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      buffer_full_r <= 1'b0;
      output_shift_register_r <= 9'h000;
      bits_left_r <= 4'h0;
      load_count_r <= 2'b00;
      clock_phase_r <= 1'b0;
    end else begin
      // a buffer write marks a word waiting
      if (wr_buffer) begin
        buffer_full_r <= 1'b1;
      end else if (move_done) begin
        buffer_full_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          // load at once when a word waits
          if (run && buffer_full_r && !wr_buffer) begin
            state_r <= ST_LOAD;
            load_count_r <= 2'b00;
          end
        end
        ST_LOAD: begin
          if (move_done) begin
            output_shift_register_r <= {transmit_control_register_r[`BIT_NINTH_BIT_VALUE],
                                        transmit_holding_buffer_r};
            bits_left_r <= nine_bit ? 4'd9 : 4'd8;
            clock_phase_r <= 1'b0;
            state_r <= ST_SHIFT;
          end else begin
            load_count_r <= load_count_r + 2'b01;
          end
        end
        ST_SHIFT: begin
          if (!run) begin
            // disabling transmit aborts the word
            state_r <= ST_IDLE;
          end else if (tick) begin
            clock_phase_r <= ~clock_phase_r;
            if (clock_phase_r) begin
              output_shift_register_r <= {1'b0, output_shift_register_r[8:1]};
              bits_left_r <= bits_left_r - 4'h1;
              // reload only after the last bit
              if (bits_left_r == 4'h1) begin
                state_r <= (buffer_full_r && !wr_buffer) ? ST_LOAD : ST_IDLE;
                load_count_r <= 2'b00;
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // buffer-empty flag with delayed drop
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      buffer_empty_flag_r <= 1'b0;
      flag_delay_r <= 2'b00;
    end else begin
      if (wr_buffer) begin
        // drop becomes visible one instruction cycle later
        flag_delay_r <= `INSTR_CYCLE_CLOCKS;
      end else if (flag_delay_r != 2'b00) begin
        flag_delay_r <= flag_delay_r - 2'b01;
      end
      // set by the move, cleared only by a write
      if (move_done) begin
        buffer_empty_flag_r <= 1'b1;
      end else if (flag_delay_r == 2'b01) begin
        buffer_empty_flag_r <= !buffer_full_r;
      end
    end
  end
  assign o_irq = buffer_empty_flag_r && peripheral_enable_register_r[`BIT_BUFFER_EMPTY];
  assign o_receive_inhibit = clocked_mode && !shifter_empty;
  // ------------------------------------------------------------
  // pin drive: enable low while driving
  // ------------------------------------------------------------
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_serial_clock_line <= 1'b0;
      o_serial_clock_line_oen <= 1'b1;
      o_serial_data_line <= 1'b0;
      o_serial_data_line_oen <= 1'b1;
    end else begin
      o_serial_clock_line_oen <= !master_active;
      o_serial_clock_line <= (state_r == ST_SHIFT) && clock_phase_r;
      // data line driven only for transmit
      o_serial_data_line_oen <= !(master_active && tx_enable);
      o_serial_data_line <= output_shift_register_r[0];
    end
  end
  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (i_haddr == `OFS_TRANSMIT_STATUS_CONTROL) begin
      rd_byte = {transmit_control_register_r[7:2], shifter_empty,
                 transmit_control_register_r[0]};
    end else if (i_haddr == `OFS_RECEIVE_STATUS_CONTROL) begin
      rd_byte = receive_control_register_r;
    end else if (i_haddr == `OFS_BAUD_RATE_DIVISOR) begin
      rd_byte = baud_divisor_register_r;
    end else if (i_haddr == `OFS_TRANSMIT_BUFFER) begin
      rd_byte = transmit_holding_buffer_r;
    end else if (i_haddr == `OFS_PERIPHERAL_FLAGS_ONE) begin
      rd_byte = {3'b000, buffer_empty_flag_r, 4'h0};
    end else if (i_haddr == `OFS_PERIPHERAL_ENABLES_ONE) begin
      rd_byte = peripheral_enable_register_r;
    end else if (i_haddr == `OFS_PERIPHERAL_PRIORITIES_ONE) begin
      rd_byte = peripheral_priorities_r;
    end else if (i_haddr == `OFS_INTERRUPT_CONTROL) begin
      rd_byte = interrupt_control_r;
    end
  end
  // shifter has no address; read data registered
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hrdata <= 32'h00000000;
    end else if (take && !i_hwrite) begin
      o_hrdata <= {24'h000000, rd_byte};
    end
  end
endmodule // sync_tx_master
`default_nettype wire

// ### bench/sync_slave_model.sv
// behavioural synchronous slave that shifts in what the master sends
`default_nettype none
module sync_slave_model (
  // serial wires as seen on the board
  input wire logic i_ck,
  input wire logic i_dt,
  // captured bits, bit count and last clock period in ns
  output var logic [31:0] o_sr,
  output var logic [7:0] o_cnt,
  output var logic [31:0] o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  time last_t = 0; // time of the previous clock rise
  logic [31:0] sr_r = 32'h0; // shifted-in bits, newest on top
  logic [7:0] cnt_r = 8'h00; // rises seen so far
  logic [31:0] period_r = 32'h0; // spacing of the last two rises
  assign o_sr = sr_r;
  assign o_cnt = cnt_r;
  assign o_period = period_r;
  always @(posedge i_ck) begin
    sr_r <= {i_dt, sr_r[31:1]};
    cnt_r <= cnt_r + 8'h01;
    period_r <= 32'($time - last_t);
    last_t <= $time;
  end
endmodule // sync_slave_model
`default_nettype wire

// ### bench/sync_tx_master_sva.sv
// checker watching the ports of the sync master transmitter
`default_nettype none
`include "sync_tx_map.vh"
module sync_tx_master_sva (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // register bus
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  // pins and status
  input wire logic o_serial_clock_line,
  input wire logic o_serial_clock_line_oen,
  input wire logic o_serial_data_line,
  input wire logic o_serial_data_line_oen,
  input wire logic o_irq,
  input wire logic o_receive_inhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // bus phase tracking
  // ----
  logic wp_r; // write data phase
  logic rp_r; // read data phase
  logic [11:0] a_r; // address of the data phase
  logic ie_r; // shadow of the irq enable bit
  wire bw = wp_r && (a_r == `OFS_TRANSMIT_BUFFER); // buffer write lands
  wire fw = wp_r && (a_r == `OFS_PERIPHERAL_FLAGS_ONE); // flag register write
  // follow address phases and the enable register
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      a_r <= 12'h000;
      ie_r <= 1'b0;
    end else begin
      if (i_hready) begin
        wp_r <= i_hsel & i_htrans[1] & i_hwrite;
        rp_r <= i_hsel & i_htrans[1] & ~i_hwrite;
        a_r <= i_haddr;
      end
      if (wp_r && (a_r == `OFS_PERIPHERAL_ENABLES_ONE)) begin
        ie_r <= i_hwdata[`BIT_BUFFER_EMPTY];
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ----
  // properties
  // ----
  property p_half; $rose(o_serial_clock_line) |-> o_receive_inhibit; endproperty
  property p_pins; !o_serial_data_line_oen |-> !o_serial_clock_line_oen; endproperty
  property p_clk; o_serial_clock_line |-> !o_serial_clock_line_oen; endproperty
  property p_data; o_serial_clock_line |-> $stable(o_serial_data_line); endproperty
  property p_gate; o_irq |-> ie_r; endproperty
  property p_lag; bw && o_irq |=> o_irq; endproperty
  property p_sticky; fw && o_irq |=> o_irq; endproperty
  property p_start;
    bw && !o_serial_data_line_oen && !o_receive_inhibit |-> ##[1:20] o_receive_inhibit;
  endproperty
  property p_hidden; rp_r && (a_r >= 12'h020) |-> o_hrdata == 32'h0; endproperty
  a_half: assert property (p_half) else $error("clock pulse outside a transfer");
  a_pins: assert property (p_pins) else $error("data driven without clock");
  a_clk: assert property (p_clk) else $error("clock high while not driven");
  a_data: assert property (p_data) else $error("data moved while clock high");
  a_gate: assert property (p_gate) else $error("irq while masked");
  a_lag: assert property (p_lag) else $error("flag dropped at once");
  a_sticky: assert property (p_sticky) else $error("flag cleared by software");
  a_start: assert property (p_start) else $error("buffer write did not start");
  a_hidden: assert property (p_hidden) else $error("unmapped read not zero");
  c_irq: cover property ($rose(o_irq));
  c_done: cover property ($fell(o_receive_inhibit));
  c_b2b: cover property (bw && o_irq);
endmodule // sync_tx_master_sva
bind sync_tx_master sync_tx_master_sva u_sva (.i_clock, .i_rstn, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_serial_clock_line,
  .o_serial_clock_line_oen, .o_serial_data_line, .o_serial_data_line_oen, .o_irq,
  .o_receive_inhibit);
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the sync master transmitter
`default_nettype none
`include "sync_tx_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // addresses, signals and counters
  // ----
  localparam logic [11:0] FLG = `OFS_PERIPHERAL_FLAGS_ONE;
  localparam logic [11:0] ENA = `OFS_PERIPHERAL_ENABLES_ONE;
  localparam logic [11:0] RSC = `OFS_RECEIVE_STATUS_CONTROL;
  localparam logic [11:0] BUF = `OFS_TRANSMIT_BUFFER;
  localparam logic [11:0] TSC = `OFS_TRANSMIT_STATUS_CONTROL;
  localparam logic [11:0] DIV = `OFS_BAUD_RATE_DIVISOR;
  localparam int DIV_VAL = 1; // small divisor keeps frames short
  localparam int BIT_NS = (DIV_VAL + 1) * 8 * 10; // two ticks of (DIV_VAL+1)*4 clocks each, 10 ns per clock
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_hsel = 1'b0;
  logic [11:0] i_haddr = 12'h000;
  logic [1:0] i_htrans = 2'b00;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'b010; // whole words only
  logic [31:0] i_hwdata = 32'h0;
  logic i_hready, o_hreadyout, o_hresp, o_irq, o_receive_inhibit;
  logic o_serial_clock_line, o_serial_clock_line_oen, i_serial_clock_line;
  logic o_serial_data_line, o_serial_data_line_oen, i_serial_data_line;
  logic [31:0] o_hrdata, sr, per, r;
  logic [7:0] bits, c0;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  assign i_hready = o_hreadyout; // the one slave drives bus ready
  // released lines fall to their pull-downs
  assign i_serial_clock_line = o_serial_clock_line_oen ? 1'b0 : o_serial_clock_line;
  assign i_serial_data_line = o_serial_data_line_oen ? 1'b0 : o_serial_data_line;
  always #5 i_clock = ~i_clock;
  sync_tx_master uut (.i_clock, .i_rstn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_serial_clock_line,
    .o_serial_clock_line, .o_serial_clock_line_oen, .i_serial_data_line,
    .o_serial_data_line, .o_serial_data_line_oen, .o_irq, .o_receive_inhibit);
  sync_slave_model sm (.i_ck(i_serial_clock_line), .i_dt(i_serial_data_line), .o_sr(sr),
    .o_cnt(bits), .o_period(per));
  // ----
  // bus, compare and wait helpers
  // ----
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= a;
    i_hwrite <= w;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    do @(posedge i_clock); while (i_hready !== 1'b1);
    r = o_hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // wait until k more bits went out and the shifter is idle
  task automatic wait_bits(input int k);
    for (n = 0; n < 900 && 32'(bits - c0) != k; n++) @(posedge i_clock);
    for (n = 0; n < 200 && o_receive_inhibit !== 1'b0; n++) @(posedge i_clock);
    chk(32'(bits - c0), k);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(TSC, 32'h02);
    rd(DIV, 32'h00);
    rd(FLG, 32'h00);
    rd(12'h040, 32'h00);
    chk({o_hreadyout, o_hresp}, 32'h2);
    wr(TSC, 32'hff);
    rd(TSC, 32'hf7);
    wr(TSC, 32'h00);
  endtask
  task automatic t_send8;
    wr(DIV, DIV_VAL);
    wr(TSC, 32'h90);
    wr(RSC, 32'h80);
    wr(ENA, 32'h10);
    wr(TSC, 32'hb0);
    c0 = bits;
    wr(BUF, 32'ha5);
    for (n = 0; n < 20 && o_irq !== 1'b1; n++) @(posedge i_clock);
    chk(32'(n < 9), 32'h1);
    rd(TSC, 32'hb0);
    rd(FLG, 32'h10);
    wait_bits(8);
    chk(sr[31:24], 32'ha5);
    chk(per, BIT_NS);
    rd(TSC, 32'hb2);
  endtask
  task automatic t_b2b;
    c0 = bits;
    wr(BUF, 32'h3c);
    chk(o_irq, 32'h1);
    for (n = 0; n < 10 && o_irq !== 1'b0; n++) @(posedge i_clock);
    chk(o_irq, 32'h0);
    for (n = 0; n < 40 && o_irq !== 1'b1; n++) @(posedge i_clock);
    chk(o_irq, 32'h1);
    wr(BUF, 32'hc3);
    wait_bits(16);
    chk(sr[31:16], 32'hc33c);
  endtask
  task automatic t_nine;
    wr(TSC, 32'hf1);
    c0 = bits;
    wr(BUF, 32'h5a);
    wait_bits(9);
    chk(sr[31:23], 32'h15a);
  endtask
  task automatic t_mask;
    wr(FLG, 32'h00);
    rd(FLG, 32'h10);
    wr(ENA, 32'h00);
    rd(FLG, 32'h10);
    chk(o_irq, 32'h0);
    wr(ENA, 32'h10);
    rd(ENA, 32'h10);
    chk(o_irq, 32'h1);
    wr(TSC, 32'h90);
    rd(RSC, 32'h80);
    chk(o_serial_data_line_oen, 32'h1);
    wr(RSC, 32'h00);
    rd(RSC, 32'h00);
    chk(o_serial_clock_line_oen, 32'h1);
  endtask
  // no transfer without clocked mode, then abort a word mid-frame
  task automatic t_mode_abort;
    wr(RSC, 32'h80);
    wr(TSC, 32'ha0);
    c0 = bits;
    wr(BUF, 32'h81);
    repeat (40) @(posedge i_clock);
    chk(32'(bits - c0), 32'h0);
    chk(o_serial_clock_line_oen, 32'h1);
    wr(TSC, 32'hb0);
    repeat (40) @(posedge i_clock);
    chk(o_receive_inhibit, 32'h1);
    wr(TSC, 32'h90);
    @(posedge i_clock);
    rd(TSC, 32'h92);
    chk(o_receive_inhibit, 32'h0);
  endtask
  // reset in mid-run restores the documented values
  task automatic t_reset;
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    rd(TSC, 32'h02);
    rd(DIV, 32'h00);
    rd(FLG, 32'h00);
    chk(o_irq, 32'h0);
  endtask
  // ----
  // verdict and run control
  // ----
  task automatic tally_and_finish;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // cut a hang short
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    t_regs;
    t_send8;
    t_b2b;
    t_nine;
    t_mask;
    t_mode_abort;
    t_reset;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
